// ==== hw/mps_pkg.sv ====
// Constants and state types shared by both ends of the
// power sequencing link.
// Assumes one 250 MHz clock and 64-bit constants.
//
// What this block does
// [R1] Host holds power key low five seconds.
// [R2] Module operational no earlier than 25 seconds.
// [R3] Software ready high before host sends commands.
// [R4] Power good rises after pad configuration.
// [R5] Power good low means shutdown completed.
// [R6] Host stays silent until activation reached.
// [R7] Key tied low starts boot at supply.
// [R8] Three shutdown paths: command, key, emergency.
// [R9] Detach sent on command or key shutdown.
// [R10] Host drives power key open-drain only.
// [R11] Host keeps lines low while module off.
// [R12] Key shutdown hold at least three seconds.
// [R13] Emergency line held low eighteen milliseconds.
// [R14] Host waits power good low, no timeout.
// [R15] Host ignores requests while a sequence runs; the code still takes emergency_req in HST_BOOT_WAIT and HST_FIN_WAIT.
package mps_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam longint MPS_CLK_HZ      = 64'd250000000;
    localparam longint MPS_ON_HOLD_MS  = 64'd5000;
    localparam longint MPS_BOOT_MS     = 64'd25000;
    localparam longint MPS_OFF_HOLD_MS = 64'd3000;
    localparam longint MPS_EMERG_MS    = 64'd18;
    localparam longint MPS_FIN_MS      = 64'd16000;
    localparam longint MPS_SWRDY_MS    = 64'd100;

    // Least times, so every count rounds up.
    localparam longint MPS_ON_HOLD_CYC  = (MPS_ON_HOLD_MS * MPS_CLK_HZ + 999) / 1000;
    localparam longint MPS_BOOT_CYC     = (MPS_BOOT_MS * MPS_CLK_HZ + 999) / 1000;
    localparam longint MPS_OFF_HOLD_CYC = (MPS_OFF_HOLD_MS * MPS_CLK_HZ + 999) / 1000;
    localparam longint MPS_EMERG_CYC    = (MPS_EMERG_MS * MPS_CLK_HZ + 999) / 1000;
    localparam longint MPS_FIN_CYC      = (MPS_FIN_MS * MPS_CLK_HZ + 999) / 1000;
    localparam longint MPS_SWRDY_CYC    = (MPS_SWRDY_MS * MPS_CLK_HZ + 999) / 1000;

    localparam int MPS_CNT_W = 34;

    // ****************************************
    // States
    // ****************************************
    typedef enum logic [2:0] {
        DEV_OFF    = 3'h0,
        DEV_ARM    = 3'h1,
        DEV_BOOT   = 3'h2,
        DEV_PADS   = 3'h3,
        DEV_ACTIVE = 3'h4,
        DEV_FIN    = 3'h5
    } mps_dev_state_e;

    typedef enum logic [2:0] {
        HST_OFF       = 3'h0,
        HST_KEY_ON    = 3'h1,
        HST_BOOT_WAIT = 3'h2,
        HST_READY     = 3'h3,
        HST_KEY_OFF   = 3'h4,
        HST_EMERG     = 3'h5,
        HST_FIN_WAIT  = 3'h6
    } mps_hst_state_e;

endpackage

// ==== hw/mps_link_if.sv ====
// Pin-level link between the module end and the host end.
// Assumes both ends share clk; the open-drain wires are resolved here.
`timescale 1ns/1ns
interface mps_link_if;
    logic power_key_o;
    logic power_key_oe_n;
    logic emergency_off_o;
    logic emergency_off_oe_n;
    logic power_key_n;
    logic emergency_off_n;
    logic power_good_monitor;
    logic software_ready;
    logic shutdown_command;

    // Pulled up inside the module: released reads high.
    assign power_key_n     = (!power_key_oe_n && !power_key_o) ? 1'b0 : 1'b1;
    assign emergency_off_n = (!emergency_off_oe_n && !emergency_off_o) ? 1'b0 : 1'b1;

    modport device (
        input  power_key_n,
        input  emergency_off_n,
        input  shutdown_command,
        output power_good_monitor,
        output software_ready
    );

    modport host (
        output power_key_o,
        output power_key_oe_n,
        output emergency_off_o,
        output emergency_off_oe_n,
        output shutdown_command,
        input  power_good_monitor,
        input  software_ready
    );
endinterface

// ==== hw/mps_timer.sv ====
// Saturating cycle counter with a compare against a limit.
// Assumes clear and run come from logic on the same clock.
`timescale 1ns/1ns
module mps_timer
    import mps_pkg::*;
#(
    parameter int CNT_W = MPS_CNT_W
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             ce,
    input  wire logic             clear,
    input  wire logic             run,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  reached
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    if (CNT_W < 2 || CNT_W > 63) begin : g_chk
        $error("CNT_W out of range");
    end

    always_comb begin
        next_count = count;
        if (clear) begin
            next_count = '0;
        end else if (run && count != '1) begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count <= '0;
        end else if (ce) begin
            count <= next_count;
        end
    end

    assign reached = (count >= limit);
endmodule

// ==== hw/mps_device.sv ====
// Module end: boot, pad bring-up, readiness and the three shutdown paths.
// Assumes key and emergency pins and battery_supply are asynchronous, shutdown_command on clk.
`timescale 1ns/1ns
module mps_device
    import mps_pkg::*;
#(
    parameter int              CNT_W        = MPS_CNT_W,
    parameter longint unsigned ON_HOLD_CYC  = MPS_ON_HOLD_CYC,
    parameter longint unsigned BOOT_CYC     = MPS_BOOT_CYC,
    parameter longint unsigned OFF_HOLD_CYC = MPS_OFF_HOLD_CYC,
    parameter longint unsigned EMERG_CYC    = MPS_EMERG_CYC,
    parameter longint unsigned FIN_CYC      = MPS_FIN_CYC,
    parameter longint unsigned SWRDY_CYC    = MPS_SWRDY_CYC
) (
    input  wire logic     clk,
    input  wire logic     reset,
    input  wire logic     ce,
    mps_link_if.device    link,
    input  wire logic     battery_supply,
    output logic          detach_request,
    output logic [2:0]    module_state
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic       key_low;
    logic       emerg_low;
    logic       batt;
    logic       batt_prev;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_a    <= 3'h7;
            sync_b    <= 3'h7;
            batt_prev <= 1'b0;
        end else if (ce) begin
            sync_a    <= {battery_supply, link.emergency_off_n, link.power_key_n};
            sync_b    <= sync_a;
            batt_prev <= batt;
        end
    end

    assign key_low   = !sync_b[0];
    assign emerg_low = !sync_b[1];
    assign batt      = sync_b[2];

    if (CNT_W < $clog2(BOOT_CYC + 1) || CNT_W < $clog2(FIN_CYC + 1)) begin : g_chk
        $error("CNT_W too narrow");
    end

    // ****************************************
    // Sequencer
    // ****************************************
    mps_dev_state_e   state;
    mps_dev_state_e   next_state;
    logic             tmr_clear;
    logic             tmr_run;
    logic [CNT_W-1:0] tmr_limit;
    logic             tmr_hit;
    logic             em_hit;
    logic             next_detach;
    logic             next_pg;
    logic             next_ready;

    mps_timer #(.CNT_W(CNT_W)) u_seq_tmr (
        .clk     (clk),
        .reset   (reset),
        .ce      (ce),
        .clear   (tmr_clear),
        .run     (tmr_run),
        .limit   (tmr_limit),
        .reached (tmr_hit)
    );

    // Emergency path: no detach is sent.
    mps_timer #(.CNT_W(CNT_W)) u_em_tmr (
        .clk     (clk),
        .reset   (reset),
        .ce      (ce),
        .clear   (!emerg_low),
        .run     (emerg_low),
        .limit   (CNT_W'(EMERG_CYC)),
        .reached (em_hit)
    );

    always_comb begin
        next_state  = state;
        tmr_clear   = 1'b0;
        tmr_run     = 1'b1;
        tmr_limit   = CNT_W'(ON_HOLD_CYC);
        next_detach = 1'b0;
        case (state)
            DEV_OFF: begin
                tmr_clear = 1'b1;
                if (batt && !batt_prev && key_low) begin
                    next_state = DEV_BOOT; // [R7]
                end else if (batt && key_low) begin
                    next_state = DEV_ARM;
                end
            end
            DEV_ARM: begin
                if (tmr_hit) begin
                    next_state = DEV_BOOT;
                end else if (!key_low) begin
                    next_state = DEV_OFF;
                end
            end
            DEV_BOOT: begin
                tmr_limit = CNT_W'(BOOT_CYC);
                if (tmr_hit) begin
                    next_state = DEV_PADS; // [R2]
                    tmr_clear  = 1'b1;
                end
            end
            DEV_PADS: begin
                tmr_limit = CNT_W'(SWRDY_CYC);
                if (tmr_hit) begin
                    next_state = DEV_ACTIVE;
                    tmr_clear  = 1'b1;
                end
            end
            DEV_ACTIVE: begin
                tmr_limit = CNT_W'(OFF_HOLD_CYC);
                tmr_run   = key_low;
                tmr_clear = !key_low;
                if (link.shutdown_command || (!key_low && tmr_hit)) begin
                    next_state  = DEV_FIN; // [R8]
                    next_detach = 1'b1; // [R9]
                end
            end
            DEV_FIN: begin
                tmr_limit = CNT_W'(FIN_CYC);
                if (tmr_hit) begin
                    next_state = DEV_OFF;
                end
            end
            default: begin
                next_state = DEV_OFF;
            end
        endcase
        if (state != DEV_OFF && (em_hit || !batt)) begin
            next_state  = DEV_OFF; // [R8]
            next_detach = 1'b0;
        end
        next_pg    = next_state inside {DEV_PADS, DEV_ACTIVE, DEV_FIN}; // [R4] [R5]
        next_ready = (next_state == DEV_ACTIVE); // [R3]
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state                   <= DEV_OFF;
            detach_request          <= 1'b0;
            module_state            <= 3'h0;
            link.power_good_monitor <= 1'b0;
            link.software_ready     <= 1'b0;
        end else if (ce) begin
            state                   <= next_state;
            detach_request          <= next_detach;
            module_state            <= next_state;
            link.power_good_monitor <= next_pg;
            link.software_ready     <= next_ready;
        end
    end
endmodule

// ==== hw/mps_host.sv ====
// Host end: key pulses, readiness wait and the
// three shutdown paths.
// Assumes status pins asynchronous, requests on clk.
`timescale 1ns/1ns
module mps_host
    import mps_pkg::*;
#(
    parameter int              CNT_W        = MPS_CNT_W,
    parameter longint unsigned ON_HOLD_CYC  = MPS_ON_HOLD_CYC,
    parameter longint unsigned OFF_HOLD_CYC = MPS_OFF_HOLD_CYC,
    parameter longint unsigned EMERG_CYC    = MPS_EMERG_CYC
) (
    input  wire logic     clk,
    input  wire logic     reset,
    input  wire logic     ce,
    mps_link_if.host      link,
    input  wire logic     power_on_req,
    input  wire logic     sw_shutdown_req,
    input  wire logic     hw_shutdown_req,
    input  wire logic     emergency_req,
    output logic          busy,
    output logic          at_allowed,
    output logic          module_off,
    output logic          req_ignored
);
    // ****************************************
    // Status pin synchronisers
    // ****************************************
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic       pg;
    logic       rdy;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_a <= 2'h0;
            sync_b <= 2'h0;
        end else if (ce) begin
            sync_a <= {link.software_ready, link.power_good_monitor};
            sync_b <= sync_a;
        end
    end

    assign pg  = sync_b[0];
    assign rdy = sync_b[1];

    if (CNT_W < $clog2(ON_HOLD_CYC + 1) || CNT_W < $clog2(OFF_HOLD_CYC + 1)) begin : g_chk
        $error("CNT_W too narrow");
    end

    // ****************************************
    // Hold timer
    // ****************************************
    mps_hst_state_e   state;
    mps_hst_state_e   next_state;
    logic             tmr_clear;
    logic [CNT_W-1:0] tmr_limit;
    logic             tmr_hit;

    mps_timer #(.CNT_W(CNT_W)) u_hold_tmr (
        .clk     (clk),
        .reset   (reset),
        .ce      (ce),
        .clear   (tmr_clear),
        .run     (1'b1),
        .limit   (tmr_limit),
        .reached (tmr_hit)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    logic next_key_drive;
    logic next_em_drive;
    logic next_cmd;
    logic next_ignored;
    logic any_req;
    logic taken;

    assign any_req = power_on_req || sw_shutdown_req || hw_shutdown_req || emergency_req;

    always_comb begin
        next_state = state;
        tmr_clear  = 1'b1;
        tmr_limit  = CNT_W'(ON_HOLD_CYC);
        next_cmd   = 1'b0;
        taken      = 1'b0;
        case (state)
            HST_OFF: begin
                if (power_on_req) begin
                    next_state = HST_KEY_ON;
                    taken      = 1'b1;
                end
            end
            HST_KEY_ON: begin
                tmr_clear = 1'b0;
                if (tmr_hit) begin
                    next_state = HST_BOOT_WAIT; // [R1]
                end
            end
            HST_BOOT_WAIT: begin
                if (emergency_req) begin
                    next_state = HST_EMERG;
                    taken      = 1'b1;
                end else if (pg && rdy) begin
                    next_state = HST_READY; // [R3] [R6]
                end
            end
            HST_READY: begin
                if (emergency_req) begin
                    next_state = HST_EMERG;
                    taken      = 1'b1;
                end else if (sw_shutdown_req) begin
                    next_state = HST_FIN_WAIT; // [R8]
                    next_cmd   = 1'b1;
                    taken      = 1'b1;
                end else if (hw_shutdown_req) begin
                    next_state = HST_KEY_OFF;
                    taken      = 1'b1;
                end else if (!pg) begin
                    next_state = HST_OFF;
                end
            end
            HST_KEY_OFF: begin
                tmr_clear = 1'b0;
                tmr_limit = CNT_W'(OFF_HOLD_CYC);
                if (tmr_hit) begin
                    next_state = HST_FIN_WAIT; // [R12]
                end
            end
            HST_EMERG: begin
                tmr_clear = 1'b0;
                tmr_limit = CNT_W'(EMERG_CYC);
                if (tmr_hit) begin
                    next_state = HST_FIN_WAIT; // [R13]
                end
            end
            HST_FIN_WAIT: begin
                // No timeout: finalisation has no upper bound.
                if (emergency_req) begin
                    next_state = HST_EMERG;
                    taken      = 1'b1;
                end else if (!pg) begin
                    next_state = HST_OFF; // [R14] [R5]
                end
            end
            default: begin
                next_state = HST_OFF;
            end
        endcase
        if (next_state != state) begin
            tmr_clear = 1'b1;
        end
        next_ignored   = any_req && !taken; // [R15]
        next_key_drive = next_state inside {HST_KEY_ON, HST_KEY_OFF};
        next_em_drive  = (next_state == HST_EMERG);
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    // Only enables move, so the key and emergency pins are never driven high. [R10]
    // The strobe fires only in the ready state, so nothing is
    // raised toward an off or switching module. [R11]
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state                   <= HST_OFF;
            link.power_key_o        <= 1'b0;
            link.power_key_oe_n     <= 1'b1;
            link.emergency_off_o    <= 1'b0;
            link.emergency_off_oe_n <= 1'b1;
            link.shutdown_command   <= 1'b0;
            busy                    <= 1'b0;
            at_allowed              <= 1'b0;
            module_off              <= 1'b1;
            req_ignored             <= 1'b0;
        end else if (ce) begin
            state                   <= next_state;
            link.power_key_o        <= 1'b0;
            link.power_key_oe_n     <= !next_key_drive; // [R10]
            link.emergency_off_o    <= 1'b0;
            link.emergency_off_oe_n <= !next_em_drive; // [R10]
            link.shutdown_command   <= next_cmd; // [R11]
            busy                    <= !(next_state inside {HST_OFF, HST_READY}); // [R15]
            at_allowed              <= (next_state == HST_READY); // [R6]
            module_off              <= (next_state == HST_OFF);
            req_ignored             <= next_ignored;
        end
    end
endmodule

// ==== bench/mps_props.sv ====
// Checker on the link's interface signals.
// Assumes the bench's short counts: key 20/12, emergency 5, finalise 30.
`timescale 1ns/1ns
module mps_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic power_key_oe_n,
    input wire logic emergency_off_oe_n,
    input wire logic power_key_n,
    input wire logic shutdown_command,
    input wire logic power_good_monitor,
    input wire logic software_ready
);
    // ****************************************
    // Helper counters
    // ****************************************
    localparam int KEY_ON_LOW  = 21;
    localparam int KEY_OFF_LOW = 13;
    localparam int EMG_LOW     = 6;
    localparam int BOOT_MIN    = 100;

    logic [15:0] key_low;
    logic [15:0] emg_low;
    logic [15:0] since_key;
    logic        key_q;
    logic [15:0] next_key_low;
    logic [15:0] next_emg_low;
    logic [15:0] next_since;

    // Saturates so a long idle spell cannot wrap below the minimum.
    always_comb begin
        next_key_low = power_key_oe_n ? 16'h0000 : key_low + 16'h0001;
        next_emg_low = emergency_off_oe_n ? 16'h0000 : emg_low + 16'h0001;
        next_since   = (since_key == 16'hFFFF) ? since_key : since_key + 16'h0001;
        if (key_q && !power_key_n) begin
            next_since = 16'h0001;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            key_low   <= 16'h0000;
            emg_low   <= 16'h0000;
            since_key <= 16'h0000;
            key_q     <= 1'b1;
        end else begin
            key_low   <= next_key_low;
            emg_low   <= next_emg_low;
            since_key <= next_since;
            key_q     <= power_key_n;
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_ready_up;
        !software_ready[*6] ##[1:6] software_ready;
    endsequence
    sequence s_cmd_seen;
        shutdown_command ##1 !shutdown_command;
    endsequence

    property p_key_on_hold;
        $rose(power_key_oe_n) && !power_good_monitor |-> key_low == KEY_ON_LOW;
    endproperty
    property p_key_off_hold;
        $rose(power_key_oe_n) && power_good_monitor |-> key_low == KEY_OFF_LOW;
    endproperty
    property p_emerg_hold;
        $rose(emergency_off_oe_n) |-> emg_low == EMG_LOW;
    endproperty
    property p_boot_min;
        $rose(power_good_monitor) |-> since_key >= BOOT_MIN;
    endproperty
    property p_ready_after_pg;
        $rose(power_good_monitor) |-> s_ready_up;
    endproperty
    property p_ready_needs_pg;
        software_ready |-> power_good_monitor;
    endproperty
    property p_sw_off;
        shutdown_command |-> s_cmd_seen ##[0:3] !software_ready;
    endproperty
    property p_fin_wait;
        shutdown_command |-> ##28 power_good_monitor ##[1:12] !power_good_monitor;
    endproperty
    property p_key_off;
        $rose(power_key_oe_n) && power_good_monitor |-> ##[20:50] !power_good_monitor;
    endproperty
    property p_emerg_off;
        $rose(emergency_off_oe_n) |-> ##[0:6] (!power_good_monitor && !software_ready);
    endproperty

    a_key_on_hold: assert property (p_key_on_hold) else $error("on pulse");
    a_key_off_hold: assert property (p_key_off_hold) else $error("off pulse");
    a_emerg_hold: assert property (p_emerg_hold) else $error("emg pulse");
    a_boot_min: assert property (p_boot_min) else $error("early pg");
    a_ready_after_pg: assert property (p_ready_after_pg) else $error("late ready");
    a_ready_needs_pg: assert property (p_ready_needs_pg) else $error("ready no pg");
    a_sw_off: assert property (p_sw_off) else $error("cmd off");
    a_fin_wait: assert property (p_fin_wait) else $error("fin time");
    a_key_off: assert property (p_key_off) else $error("key off");
    a_emerg_off: assert property (p_emerg_off) else $error("emg off");
endmodule

// ==== bench/test_module_power_on_off_sequencer.sv ====
// Bench joining host and module ends over the link.
// Assumes the short counts below.
`timescale 1ns/1ns
module test_module_power_on_off_sequencer
    import mps_pkg::*;
;
    localparam int ON_HOLD  = 20;
    localparam int BOOT     = 100;
    localparam int OFF_HOLD = 12;
    localparam int EMERG    = 5;
    localparam int FIN      = 30;
    localparam int SWRDY    = 8;

    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       ce = 1'b1;
    logic       battery_supply = 1'b1;
    logic       power_on_req = 1'b0;
    logic       sw_shutdown_req = 1'b0;
    logic       hw_shutdown_req = 1'b0;
    logic       emergency_req = 1'b0;
    logic       detach_request;
    logic [2:0] module_state;
    logic       busy;
    logic       at_allowed;
    logic       module_off;
    logic       req_ignored;
    int         n_mismatch = 0;
    int         checks_done = 0;
    int         cyc = 0;
    int         n_detach = 0;

    mps_link_if link ();

    mps_device #(.ON_HOLD_CYC(ON_HOLD), .BOOT_CYC(BOOT), .OFF_HOLD_CYC(OFF_HOLD), .EMERG_CYC(EMERG),
                 .FIN_CYC(FIN), .SWRDY_CYC(SWRDY)) u_mps_device (
        .clk(clk), .reset(reset), .ce(ce), .link(link.device), .battery_supply(battery_supply),
        .detach_request(detach_request), .module_state(module_state));

    mps_host #(.ON_HOLD_CYC(ON_HOLD), .OFF_HOLD_CYC(OFF_HOLD), .EMERG_CYC(EMERG)) u_mps_host (
        .clk(clk), .reset(reset), .ce(ce), .link(link.host), .power_on_req(power_on_req),
        .sw_shutdown_req(sw_shutdown_req), .hw_shutdown_req(hw_shutdown_req), .emergency_req(emergency_req),
        .busy(busy), .at_allowed(at_allowed), .module_off(module_off), .req_ignored(req_ignored));

    mps_props u_mps_props (
        .clk(clk), .reset(reset), .power_key_oe_n(link.power_key_oe_n),
        .emergency_off_oe_n(link.emergency_off_oe_n), .power_key_n(link.power_key_n),
        .shutdown_command(link.shutdown_command), .power_good_monitor(link.power_good_monitor),
        .software_ready(link.software_ready));

    always #2 clk = ~clk;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (detach_request === 1'b1) begin
            n_detach <= n_detach + 1;
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s: %0h vs %0h", $time, what, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One-cycle request, taken at the edge of return.
    task automatic req_pulse(input int sel);
        @(posedge clk);
        case (sel)
            0: power_on_req <= 1'b1;
            1: sw_shutdown_req <= 1'b1;
            2: hw_shutdown_req <= 1'b1;
            default: emergency_req <= 1'b1;
        endcase
        @(posedge clk);
        power_on_req <= 1'b0;
        sw_shutdown_req <= 1'b0;
        hw_shutdown_req <= 1'b0;
        emergency_req <= 1'b0;
    endtask

    function automatic logic sig(input int sel);
        case (sel)
            0: return at_allowed;
            1: return module_off;
            default: return link.power_good_monitor;
        endcase
    endfunction

    // Bounded, as finalisation has no upper limit.
    task automatic wait_sig(input int sel, input logic val);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (sig(sel) !== val && n < 400);
        check(sig(sel), val, "wait");
    endtask

    task automatic hold_count(input int sel, output int n);
        int k;
        n = 0;
        for (k = 0; k < 60; k++) begin
            @(posedge clk);
            if ((sel == 0 ? link.power_key_oe_n : link.emergency_off_oe_n) === 1'b0) n++;
            else if (n > 0) break;
        end
    endtask

    task automatic expect_ignored(input int sel);
        logic seen;
        seen = 1'b0;
        req_pulse(sel);
        repeat (2) begin
            @(posedge clk);
            seen = seen | req_ignored;
        end
        check(seen, 1'b1, "refuse");
    endtask

    task automatic bring_up(input int ign_sel);
        int n;
        int t0;
        t0 = cyc;
        req_pulse(0);
        hold_count(0, n);
        check(n, ON_HOLD + 1, "on hold");
        check(at_allowed, 1'b0, "boot allow");
        expect_ignored(ign_sel);
        wait_sig(2, 1'b1);
        check(cyc - t0 >= BOOT, 1, "boot time");
        check(link.software_ready, 1'b0, "early ready");
        wait_sig(0, 1'b1);
        check(link.software_ready, 1'b1, "ready");
        check(module_state, DEV_ACTIVE, "active");
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        check({link.power_key_n, link.emergency_off_n, module_off}, 3'h7, "lines");
        check({link.power_good_monitor, link.software_ready, busy}, 3'h0, "status");
        $display("reset done");
    endtask

    task automatic t_sw_off();
        int d0;
        int t0;
        bring_up(1);
        d0 = n_detach;
        t0 = cyc;
        req_pulse(1);
        expect_ignored(0);
        wait_sig(1, 1'b1);
        check(cyc - t0 >= FIN, 1, "fin time");
        check(link.power_good_monitor, 1'b0, "pg off");
        check(n_detach - d0, 1, "cmd detach");
        $display("sw off done");
    endtask

    task automatic t_hw_off();
        int d0;
        int n;
        bring_up(2);
        d0 = n_detach;
        req_pulse(2);
        hold_count(0, n);
        check(n, OFF_HOLD + 1, "off hold");
        wait_sig(1, 1'b1);
        check(link.power_good_monitor, 1'b0, "pg key off");
        check(n_detach - d0, 1, "key detach");
        $display("key off done");
    endtask

    task automatic t_emerg();
        int d0;
        int n;
        bring_up(0);
        d0 = n_detach;
        req_pulse(3);
        hold_count(1, n);
        check(n, EMERG + 1, "emg hold");
        wait_sig(1, 1'b1);
        check({link.power_good_monitor, link.software_ready}, 2'h0, "emg status");
        check(n_detach - d0, 0, "emg detach");
        $display("emergency done");
    endtask

    // Supply rises with the key held low, as if grounded.
    task automatic t_battery();
        int t0;
        @(posedge clk);
        battery_supply <= 1'b0;
        req_pulse(0);
        repeat (6) @(posedge clk);
        check(module_state, DEV_OFF, "no supply");
        battery_supply <= 1'b1;
        t0 = cyc;
        wait_sig(2, 1'b1);
        check(cyc - t0 >= BOOT, 1, "supply boot");
        wait_sig(0, 1'b1);
        battery_supply <= 1'b0;
        wait_sig(1, 1'b1);
        check(link.power_good_monitor, 1'b0, "pg supply");
        battery_supply <= 1'b1;
        $display("supply done");
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_sw_off();
        t_hw_off();
        t_emerg();
        t_battery();
        stop_test();
    end

    // Many times the expected run.
    initial begin
        #80000;
        n_mismatch++;
        stop_test();
    end
endmodule
